// [design/ttr_pkg.sv]
// Overview of operation
// - Mode byte 0xFF selects table travel behaviour
// - Bit 4: single block or linked sequence
// - Bit 6: start from select or last block
// - Bit 9 rising starts; low stops on ramp
// - Bits 15:11 give block n, start n+1
// - Block number captured only at start edge
// - Halt decelerates block; clearing halt resumes it
// - Status bit 8 high while block runs
// - Sequence ends at next setting 0,-1,-2,-3
// - Active block object shows executing block
// - Resume plus new start edge restarts interrupted
// - No resumable block: fall back to select
// - Resume object reads -1 unless interrupted
// - Target reached: window, or halted at standstill
// - Status bit 12: gear used and coupled
// - Start and stop only in operation enabled
package ttr_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int CW_W      = 16;
  localparam int CW_SEQ    = 4;
  localparam int CW_RES    = 6;
  localparam int CW_HALT   = 8;
  localparam int CW_START  = 9;
  localparam int CW_SEL_LO = 11;
  localparam int SEL_W     = 5;
  localparam int SW_BIP    = 8;
  localparam int SW_TGT    = 10;
  localparam int SW_GEAR   = 12;
  localparam int SW_FERR   = 13;
  localparam int BLK_W     = 8;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [3:0]       CW_OPEN_NIB  = 4'hf;
  localparam logic [7:0]       MODE_TTR     = 8'hff;
  localparam logic [7:0]       BLK_NONE     = 8'hff;
  localparam logic [7:0]       BLK_FIRST    = 8'h01;
  localparam logic signed [7:0] NB_END      = 8'sh00;
  localparam logic signed [7:0] NB_ERR      = 8'shff;
  localparam logic signed [7:0] NB_STOP_ERR = 8'shfe;
  localparam logic signed [7:0] NB_QSTP_ERR = 8'shfd;
  localparam logic [15:0]      CW_RST       = 16'h0000;
  localparam logic [15:0]      SW_RST       = 16'h0000;
  localparam logic [7:0]       MODE_RST     = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HALT, ST_STOP} ttr_state_t;

  typedef struct packed {
    logic             run;
    logic             load;
    logic [7:0]       blk;
    logic             ramp_stop;
    logic             halt;
  } ttr_mcmd_t;

  typedef struct packed {
    logic             done;
    logic signed [7:0] next_blk;
    logic             vel_zero;
    logic             in_window;
    logic             pos_blk;
  } ttr_meng_t;

  localparam ttr_mcmd_t MCMD_RST = '{run: 1'b0, load: 1'b0, blk: 8'h00,
                                     ramp_stop: 1'b0, halt: 1'b0};

endpackage

// [design/ttr_sync3.sv]
`timescale 1ns/1ns
module ttr_sync3 import ttr_pkg::*; #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Raw and filtered levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  wire  [W-1:0] agree = ~(s2_r ^ s3_r);

  if (W < 1) begin : g_chk
    $error("ttr_sync3 needs W of at least 1");
  end

  // A bit only moves once the last two stages agree
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      dout <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      dout <= (dout & ~agree) | (s3_r & agree);
    end
  end

endmodule // ttr_sync3

// [design/ttr_blk_pick.sv]
`timescale 1ns/1ns
module ttr_blk_pick import ttr_pkg::*; #(
  parameter int SW = SEL_W
) (
  // Command fields
  input  wire logic [SW-1:0]    sel,
  input  wire logic             resume_req,
  // Resume store
  input  wire logic             resume_ok,
  input  wire logic [BLK_W-1:0] resume_blk,
  // Chosen block
  output logic      [BLK_W-1:0] blk,
  output logic                  used_resume
);

  if (SW < 1 || SW >= BLK_W) begin : g_chk
    $error("ttr_blk_pick select width does not fit block width");
  end

  wire [BLK_W-1:0] sel_blk = BLK_W'(sel) + BLK_FIRST;

  assign used_resume = resume_req & resume_ok;
  assign blk         = used_resume ? resume_blk : sel_blk;

endmodule // ttr_blk_pick

// [design/ttr_ctrl.sv]
`timescale 1ns/1ns
module ttr_ctrl import ttr_pkg::*; (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Field bus objects
  input  wire logic [CW_W-1:0]  drive_command_word,
  input  wire logic [7:0]       mode_sel,
  output logic      [CW_W-1:0]  drive_state_word,
  output logic      [BLK_W-1:0] active_blk,
  output logic      [BLK_W-1:0] resume_blk,
  // Power state bits from the drive state machine
  input  wire logic [7:0]       power_stat,
  // Motion engine
  input  wire ttr_meng_t        meng,
  output ttr_mcmd_t             mcmd,
  // Gear and following error
  input  wire logic             gear_used,
  input  wire logic             gear_cpl_pin,
  input  wire logic             ferr_pin
);

  // ----------------------------------------------------------------
  // Command capture
  // ----------------------------------------------------------------
  logic [CW_W-1:0] ctl_r;
  logic [CW_W-1:0] ctl_q;
  logic [7:0]      mode_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_r  <= CW_RST;
      ctl_q  <= CW_RST;
      mode_r <= MODE_RST;
    end else begin
      ctl_r  <= drive_command_word;
      ctl_q  <= ctl_r;
      mode_r <= mode_sel;
    end
  end

  wire             mode_ok    = (mode_r == MODE_TTR);
  wire             op_en      = mode_ok && (ctl_r[3:0] == CW_OPEN_NIB);
  wire             trig_lvl   = ctl_r[CW_START];
  wire             start_rise = ctl_r[CW_START] & ~ctl_q[CW_START];
  wire             halt_lvl   = ctl_r[CW_HALT];
  wire             seq_lvl    = ctl_r[CW_SEQ];
  wire             res_lvl    = ctl_r[CW_RES];
  wire [SEL_W-1:0] sel        = ctl_r[CW_SEL_LO +: SEL_W];

  // ----------------------------------------------------------------
  // Pin filters
  // ----------------------------------------------------------------
  logic [1:0] pins_s;

  ttr_sync3 #(.W(2)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     ({gear_cpl_pin, ferr_pin}),
    .dout    (pins_s)
  );

  wire gear_cpl_s = pins_s[1];
  wire ferr_s     = pins_s[0];

  // ----------------------------------------------------------------
  // Start block choice
  // ----------------------------------------------------------------
  logic             resume_ok_r;
  logic [BLK_W-1:0] resume_blk_r;
  logic [BLK_W-1:0] pick_blk;
  logic             pick_res;

  ttr_blk_pick #(.SW(SEL_W)) u_pick (
    .sel         (sel),
    .resume_req  (res_lvl),
    .resume_ok   (resume_ok_r),
    .resume_blk  (resume_blk_r),
    .blk         (pick_blk),
    .used_resume (pick_res)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  ttr_state_t       state_r;
  ttr_state_t       state_nxt;
  logic [BLK_W-1:0] blk_r;
  logic [BLK_W-1:0] blk_nxt;
  logic             seq_run_r;
  logic             seq_run_nxt;
  logic             load_nxt;

  // Any setting above zero links on; zero and the error codes end it
  wire next_link  = (meng.next_blk > NB_END);
  wire keep_going = op_en && trig_lvl;
  wire begin_blk  = op_en && start_rise;

  always_comb begin
    state_nxt   = state_r;
    blk_nxt     = blk_r;
    seq_run_nxt = seq_run_r;
    load_nxt    = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (begin_blk) begin
          state_nxt   = ST_RUN;
          blk_nxt     = pick_blk;
          seq_run_nxt = seq_lvl;
          load_nxt    = 1'b1;
        end
      end
      ST_RUN: begin
        if (!keep_going) begin
          state_nxt = ST_STOP;
        end else if (halt_lvl) begin
          state_nxt = ST_HALT;
        end else if (meng.done) begin
          if (seq_run_r && next_link) begin
            blk_nxt  = BLK_W'(meng.next_blk);
            load_nxt = 1'b1;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_HALT: begin
        if (!keep_going) begin
          state_nxt = ST_STOP;
        end else if (!halt_lvl) begin
          state_nxt = ST_RUN;
        end
      end
      ST_STOP: begin
        // A new start waits until the axle stands still
        if (meng.vel_zero) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r   <= ST_IDLE;
      blk_r     <= BLK_NONE;
      seq_run_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      blk_r     <= blk_nxt;
      seq_run_r <= seq_run_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Resume store
  // ----------------------------------------------------------------
  // Only a ramp stop, from the start bit or operation enabled dropping, makes a block resumable
  wire interrupt = (state_r == ST_RUN || state_r == ST_HALT) && (state_nxt == ST_STOP);
  wire finished  = (state_r == ST_RUN) && (state_nxt == ST_IDLE);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      resume_ok_r  <= 1'b0;
      resume_blk_r <= BLK_NONE;
    end else if (interrupt) begin
      resume_ok_r  <= 1'b1;
      resume_blk_r <= blk_r;
    end else if (load_nxt && state_r == ST_IDLE) begin
      resume_ok_r  <= 1'b0;
    end else if (finished) begin
      resume_ok_r  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Target reached
  // ----------------------------------------------------------------
  logic pos_tgt_r;
  // Engine status still shows the old block while a load is handed over
  wire  pos_hit = (state_r == ST_RUN) && meng.pos_blk && meng.in_window && !mcmd.load;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pos_tgt_r <= 1'b0;
    end else if (pos_hit) begin
      pos_tgt_r <= 1'b1;
    end else if (load_nxt || mcmd.load) begin
      pos_tgt_r <= 1'b0;
    end
  end

  wire tgt_nxt = halt_lvl ? meng.vel_zero : (pos_tgt_r | pos_hit);

  // ----------------------------------------------------------------
  // Published words
  // ----------------------------------------------------------------
  logic [CW_W-1:0] sw_nxt;

  always_comb begin
    sw_nxt          = SW_RST;
    sw_nxt[7:0]     = power_stat;
    sw_nxt[SW_BIP]  = (state_nxt != ST_IDLE);
    sw_nxt[SW_TGT]  = tgt_nxt;
    sw_nxt[SW_GEAR] = gear_used & gear_cpl_s;
    sw_nxt[SW_FERR] = ferr_s;
  end

  wire [BLK_W-1:0] act_nxt = (state_nxt != ST_IDLE) ? blk_nxt : BLK_NONE;
  wire [BLK_W-1:0] res_nxt = resume_ok_r ? resume_blk_r : BLK_NONE;

  ttr_mcmd_t mcmd_nxt;

  always_comb begin
    mcmd_nxt           = MCMD_RST;
    mcmd_nxt.run       = (state_nxt == ST_RUN);
    mcmd_nxt.load      = load_nxt;
    mcmd_nxt.blk       = blk_nxt;
    mcmd_nxt.ramp_stop = (state_nxt == ST_STOP);
    mcmd_nxt.halt      = (state_nxt == ST_HALT);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      drive_state_word <= SW_RST;
      active_blk       <= BLK_NONE;
      resume_blk       <= BLK_NONE;
      mcmd             <= MCMD_RST;
    end else begin
      drive_state_word <= sw_nxt;
      active_blk       <= act_nxt;
      resume_blk       <= res_nxt;
      mcmd             <= mcmd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  wire idle_go = (state_r == ST_IDLE) && op_en && start_rise;

  mode_gate_a: assert property (
    (state_r == ST_IDLE && !mode_ok) |=> (state_r == ST_IDLE && !mcmd.load))
    else $error("block started outside table travel mode");

  enable_gate_a: assert property (
    (state_r == ST_IDLE && ctl_r[3:0] != CW_OPEN_NIB) |=> state_r == ST_IDLE)
    else $error("block started without operation enabled");

  rise_start_a: assert property (
    idle_go |=> (state_r == ST_RUN && mcmd.load && mcmd.run) ##1 !mcmd.load)
    else $error("start edge did not launch one block");

  trig_stop_a: assert property (
    (state_r == ST_RUN && !trig_lvl) |=> (state_r == ST_STOP && mcmd.ramp_stop))
    else $error("start bit low did not ramp stop");

  block_num_a: assert property (
    (idle_go && !res_lvl) |=> mcmd.blk == BLK_W'($past(sel)) + BLK_FIRST)
    else $error("start block is not select plus one");

  capture_hold_a: assert property (
    (state_r == ST_RUN && !load_nxt) |=> $stable(blk_r))
    else $error("running block changed without a load");

  halt_entry_a: assert property (
    (state_r == ST_RUN && keep_going && halt_lvl) |=> (state_r == ST_HALT && mcmd.halt))
    else $error("halt did not interrupt the block");

  halt_resume_a: assert property (
    (state_r == ST_HALT && keep_going && !halt_lvl)
      |=> (state_r == ST_RUN && $stable(blk_r)))
    else $error("clearing halt did not resume the block");

  bip_state_a: assert property (
    drive_state_word[SW_BIP] == (state_r != ST_IDLE))
    else $error("in progress bit disagrees with sequencer");

  seq_step_a: assert property (
    (state_r == ST_RUN && keep_going && !halt_lvl && meng.done && seq_run_r && next_link)
      |=> (mcmd.load && mcmd.blk == BLK_W'($past(meng.next_blk))))
    else $error("sequence did not link to next block");

  seq_end_a: assert property (
    (state_r == ST_RUN && keep_going && !halt_lvl && meng.done
      && !(seq_run_r && next_link)) |=> !drive_state_word[SW_BIP])
    else $error("in progress bit stayed after the end");

  active_pub_a: assert property (
    (state_r != ST_IDLE) |-> active_blk == blk_r)
    else $error("active block object is stale");

  resume_use_a: assert property (
    (idle_go && res_lvl && resume_ok_r) |=> mcmd.blk == $past(resume_blk_r))
    else $error("resume did not restart the interrupted block");

  fallback_a: assert property (
    (idle_go && res_lvl && !resume_ok_r) |=> mcmd.blk == BLK_W'($past(sel)) + BLK_FIRST)
    else $error("resume without a valid block did not fall back");

  resume_none_a: assert property (
    (finished ##1 !interrupt) |=> resume_blk == BLK_NONE)
    else $error("resume object not minus one after completion");

  tgt_halt_a: assert property (
    halt_lvl |=> drive_state_word[SW_TGT] == $past(meng.vel_zero))
    else $error("target reached wrong while halted");

  gear_bit_a: assert property (
    1'b1 |=> drive_state_word[SW_GEAR] == $past(gear_used && gear_cpl_s))
    else $error("in gear bit wrong");

  ferr_bit_a: assert property (
    1'b1 |=> drive_state_word[SW_FERR] == $past(ferr_s))
    else $error("following error bit wrong");

  tgt_fresh_a: assert property (
    mcmd.load |=> !pos_tgt_r)
    else $error("target reached carried into a new block");

  resume_set_a: assert property (
    interrupt |=> ##1 resume_blk == $past(blk_r, 2))
    else $error("resume object does not show the interrupted block");

  seq_capture_a: assert property (
    idle_go |=> seq_run_r == $past(seq_lvl))
    else $error("sequence bit not captured at the start edge");

  stop_idle_a: assert property (
    (state_r == ST_STOP && meng.vel_zero)
      |=> (state_r == ST_IDLE && !drive_state_word[SW_BIP]))
    else $error("ramp stop did not end at standstill");

  single_done_c: cover property (
    idle_go && !seq_lvl ##[1:50] finished);

  seq_link_c: cover property (
    state_r == ST_RUN && meng.done && seq_run_r && next_link && keep_going && !halt_lvl);

  halt_back_c: cover property (
    state_r == ST_HALT ##[1:50] state_r == ST_RUN);

  resume_c: cover property (
    idle_go && res_lvl && resume_ok_r);

endmodule // ttr_ctrl

// [verif/ttr_engine_model.sv]
`timescale 1ns/1ns
module ttr_engine_model import ttr_pkg::*; (
  // Clock and reset
  input  wire logic      clk_sys,
  input  wire logic      rst,
  // Pace and commands
  input  wire logic      slow,
  input  wire ttr_mcmd_t mcmd,
  // Engine status
  output ttr_meng_t      meng
);
  // ----------------------------------------------------------------
  // Travel and speed
  // ----------------------------------------------------------------
  logic [4:0]        dist_r;
  logic [1:0]        spd_r;
  logic [7:0]        blk_r;
  logic              done_r;
  logic signed [7:0] next_w;

  // Chain 4-5-6 ends normally; 7, 8 and 9 end with each error code
  assign next_w = (blk_r == 8'h04) ? 8'sh05 :
                  (blk_r == 8'h05) ? 8'sh06 :
                  (blk_r == 8'h07) ? NB_STOP_ERR :
                  (blk_r == 8'h08) ? NB_ERR :
                  (blk_r == 8'h09) ? NB_QSTP_ERR : NB_END;

  // Speed decays over a few cycles once run drops, so standstill lags
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dist_r <= 5'h00;
      spd_r  <= 2'h0;
      blk_r  <= 8'h00;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (mcmd.load) begin
        blk_r  <= mcmd.blk;
        dist_r <= slow ? 5'h14 : 5'h04;
        spd_r  <= 2'h3;
      end else if (mcmd.run) begin
        spd_r  <= 2'h3;
        done_r <= (dist_r == 5'h01);
        if (dist_r != 5'h00) begin
          dist_r <= dist_r - 5'h01;
        end
      end else if (spd_r != 2'h0) begin
        spd_r <= spd_r - 2'h1;
      end
    end
  end

  // Block 32 is a move without positioning, so it never reaches a target
  assign meng = '{done: done_r, next_blk: next_w, vel_zero: (spd_r == 2'h0),
                  in_window: (dist_r <= 5'h01) && (blk_r != 8'h00),
                  pos_blk: (blk_r != 8'h20)};

endmodule // ttr_engine_model

// [verif/testbench.sv]
`timescale 1ns/1ns
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench import ttr_pkg::*; ;
  logic             clk_sys;
  logic             rst;
  logic [CW_W-1:0]  drive_command_word;
  logic [7:0]       mode_sel;
  logic [CW_W-1:0]  drive_state_word;
  logic [BLK_W-1:0] active_blk;
  logic [BLK_W-1:0] resume_blk;
  logic [7:0]       power_stat;
  ttr_meng_t        meng;
  ttr_mcmd_t        mcmd;
  logic             gear_used;
  logic             gear_cpl_pin;
  logic             ferr_pin;
  logic             slow;
  int               bad_count;
  int               samples_checked;
  int               loads;
  int               n0;
  logic [4:0]       sels [4] = '{5'h00, 5'h03, 5'h10, 5'h1f};

  ttr_ctrl dut (.clk_sys(clk_sys), .rst(rst), .drive_command_word(drive_command_word),
    .mode_sel(mode_sel), .drive_state_word(drive_state_word), .active_blk(active_blk),
    .resume_blk(resume_blk), .power_stat(power_stat), .meng(meng), .mcmd(mcmd),
    .gear_used(gear_used), .gear_cpl_pin(gear_cpl_pin), .ferr_pin(ferr_pin));

  ttr_engine_model eng (.clk_sys(clk_sys), .rst(rst), .slow(slow), .mcmd(mcmd), .meng(meng));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (mcmd.load === 1'b1) begin
      loads++;
    end
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [15:0] v);
    @(posedge clk_sys);
    drive_command_word <= v;
  endtask

  // Word taken at the next edge, answer one edge after that
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic go(input logic [15:0] v, input logic [7:0] exp_blk);
    wr(v & 16'hfdff);
    wr(v);
    settle();
    `CHK(mcmd.blk, exp_blk)
    `CHK(active_blk, exp_blk)
    `CHK(drive_state_word[SW_BIP], 1'b1)
  endtask

  task automatic wait_blk(input logic [7:0] b);
    int i;
    for (i = 0; i < 100 && active_blk !== b; i++) begin
      @(posedge clk_sys);
      #1;
    end
    `CHK(active_blk, b)
  endtask

  task automatic wait_idle;
    int i;
    for (i = 0; i < 200 && drive_state_word[SW_BIP] !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    `CHK(drive_state_word[SW_BIP], 1'b0)
    `CHK(active_blk, BLK_NONE)
  endtask

  task automatic finish_test;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    drive_command_word = 16'h0000;
    mode_sel = MODE_RST;
    power_stat = 8'h50;
    gear_used = 1'b0;
    gear_cpl_pin = 1'b0;
    ferr_pin = 1'b0;
    slow = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    `CHK(resume_blk, BLK_NONE)
    `CHK(active_blk, BLK_NONE)
    wr(16'h0006);
    wr(16'h0007);
    mode_sel <= MODE_TTR;
    power_stat <= 8'h37;
    wr(16'h000f);
    settle();
    `CHK(drive_state_word, 16'h0037)
    for (int k = 0; k < 4; k++) begin
      n0 = loads;
      go({sels[k], 2'b01, 9'h00f}, {3'h0, sels[k]} + 8'h01);
      if (k == 0) begin
        wr(16'hfa0f);
        settle();
        `CHK(active_blk, 8'h01)
      end
      wait_idle();
      `CHK(loads - n0, 1)
      `CHK(drive_state_word[SW_TGT], (k < 3) ? 1'b1 : 1'b0)
    end
    slow <= 1'b0;
    go({5'h03, 2'b01, 9'h01f}, 8'h04);
    wait_blk(8'h05);
    wait_blk(8'h06);
    wait_idle();
    for (int k = 6; k < 9; k++) begin
      n0 = loads;
      go({k[4:0], 2'b01, 9'h01f}, k[7:0] + 8'h01);
      wait_idle();
      `CHK(loads - n0, 1)
    end
    slow <= 1'b1;
    go(16'h020f, 8'h01);
    wr(16'h030f);
    settle();
    `CHK({mcmd.halt, mcmd.run, drive_state_word[SW_BIP]}, 3'b101)
    `CHK(drive_state_word[SW_TGT], 1'b0)
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK(drive_state_word[SW_TGT], 1'b1)
    wr(16'h020f);
    settle();
    `CHK({mcmd.halt, mcmd.run, mcmd.blk}, {2'b01, 8'h01})
    `CHK(resume_blk, BLK_NONE)
    wait_idle();
    go({5'h02, 2'b01, 9'h00f}, 8'h03);
    wr({5'h02, 2'b00, 9'h00f});
    settle();
    `CHK({mcmd.ramp_stop, mcmd.run}, 2'b10)
    wait_idle();
    `CHK(resume_blk, 8'h03)
    go({5'h09, 2'b01, 9'h04f}, 8'h03);
    wait_idle();
    `CHK(resume_blk, BLK_NONE)
    go({5'h05, 2'b01, 9'h04f}, 8'h06);
    wait_idle();
    wr(16'h0007);
    mode_sel <= 8'h01;
    wr(16'h000f);
    wr(16'h020f);
    settle();
    `CHK({drive_state_word[SW_BIP], active_blk}, {1'b0, BLK_NONE})
    wr(16'h0007);
    mode_sel <= MODE_TTR;
    wr(16'h0207);
    settle();
    `CHK({drive_state_word[SW_BIP], mcmd.run}, 2'b00)
    @(posedge clk_sys);
    gear_used <= 1'b1;
    gear_cpl_pin <= 1'b1;
    ferr_pin <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK(drive_state_word[SW_FERR:SW_GEAR], 2'b11)
    @(posedge clk_sys);
    gear_used <= 1'b0;
    ferr_pin <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK(drive_state_word[SW_FERR:SW_GEAR], 2'b00)
    finish_test();
  end

  // A hang well past the expected few hundred cycles ends the run
  initial begin
    #(40 * 30000);
    bad_count++;
    finish_test();
  end

endmodule // testbench
